// [hdl/brg_pkg.sv]
package brg_pkg;

    // =========================================================
    // timing
    // =========================================================
    // system clock period in picoseconds (125 MHz)
    localparam int unsigned CLK_PERIOD_PS = 8000;
    // pull-up recovery time after release, in system clock periods
    localparam int unsigned PULLUP_PERIODS = 2;
    // recovery count in cycles of mclk (one system clock per cycle)
    localparam int unsigned PULLUP_CYCLES = PULLUP_PERIODS;
    localparam logic [1:0] PULLUP_CNT = 2'(PULLUP_CYCLES);

    // =========================================================
    // reset values
    // =========================================================
    localparam logic PCLK_RESET = 1'b0;
    localparam logic SYNC_RESET = 1'b1;

    // =========================================================
    // carriers
    // =========================================================
    // active-low ready sources from the address decoder
    typedef struct packed {
        logic sync_ready_in_n;
        logic sync_ready_enable_n;
        logic async_ready_in_n;
        logic async_ready_enable_n;
    } brg_ready_src_s;

    // active-low cycle status from the processor
    typedef struct packed {
        logic cycle_status_high_n;
        logic cycle_status_low_n;
    } brg_status_s;

    // open-collector ready pin, two signals
    typedef struct packed {
        logic ready_out;
        logic ready_oe;
    } brg_ready_pin_s;

endpackage

// [hdl/brg_ready_gen.sv]
// How it works
// - two ready sources, each with its own enable, merge into one ready.
// - ready is open collector: it pulls low or lets go, never drives high.
// - a status bit sampled low at a clock edge releases ready.
// - after such a release, two clock periods pass before ready may pull.
// - system reset drives ready low, starting two clocks after the synchronised reset rises.
// - sync inputs are sampled only with both status high and pclk high.
// - sync ready and its enable sampled low pull ready low.
// - async inputs go through a synchroniser sampled on every clock edge.
// - the synchronised async pair is examined while pclk is high.
// - a resolved async ready overrides the sync inputs for that decision.
// - ready holds until a status bit goes low or the inputs go inactive.
// - pclk runs at half the clock rate with equal high and low times.
`timescale 1ns/1ps
module brg_ready_gen #(
    // pull-up recovery after a cycle-start release, in mclk cycles
    parameter int unsigned PULLUP_CYCLES = brg_pkg::PULLUP_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // system reset level from the reset generator
    input wire logic sys_reset,
    // pins from the address decoder and slow devices
    input wire brg_pkg::brg_ready_src_s ready_src,
    // status pins from the processor
    input wire brg_pkg::brg_status_s status,
    // peripheral clock phase and open-collector ready pin
    output logic pclk,
    output brg_pkg::brg_ready_pin_s ready_pin
);

    // =========================================================
    // parameter check
    // =========================================================
    // two bits of counter, and the line needs at least two periods
    if (PULLUP_CYCLES < 2 || PULLUP_CYCLES > 3) begin : g_bad_pullup
        $error("pull-up recovery count must be 2 or 3");
    end

    // =========================================================
    // input synchronisers (pins come from outside mclk)
    // =========================================================
    brg_pkg::brg_ready_src_s src_meta;
    brg_pkg::brg_ready_src_s src_sync;
    brg_pkg::brg_status_s st_meta;
    brg_pkg::brg_status_s st_sync;
    logic rst_meta;
    logic rst_sync;

    // two flops per pin; async pair resolves here every edge
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            src_meta <= {4{brg_pkg::SYNC_RESET}};
            src_sync <= {4{brg_pkg::SYNC_RESET}};
            st_meta <= {2{brg_pkg::SYNC_RESET}};
            st_sync <= {2{brg_pkg::SYNC_RESET}};
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            src_meta <= ready_src;
            src_sync <= src_meta;
            st_meta <= status;
            st_sync <= st_meta;
            rst_meta <= sys_reset;
            rst_sync <= rst_meta;
        end
    end

    // =========================================================
    // peripheral clock phase
    // =========================================================
    // toggles each cycle: half rate, 50 percent duty
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pclk <= brg_pkg::PCLK_RESET;
        end else begin
            pclk <= ~pclk;
        end
    end

    // =========================================================
    // ready decision
    // =========================================================
    wire status_active = ~st_sync.cycle_status_high_n
                       | ~st_sync.cycle_status_low_n;
    // active-low pairs: both low selects and terminates
    wire async_hit = ~src_sync.async_ready_in_n
                   & ~src_sync.async_ready_enable_n;
    wire sync_hit = ~src_sync.sync_ready_in_n
                  & ~src_sync.sync_ready_enable_n;
    wire sample_ok = pclk & ~status_active;
    // async wins; sync only looked at when async not resolved
    wire async_take = pclk & async_hit;
    wire sync_take = sample_ok & ~async_hit & sync_hit;
    wire source_take = async_take | sync_take;
    // inputs seen inactive at a sampling point end the pull
    wire source_drop = pclk & ~async_hit & ~(sync_hit & ~status_active);

    logic ready_active;
    logic next_ready_active;
    logic [1:0] recover;
    logic reset_seen;
    // load value of the recovery counter, cut to its width on purpose
    localparam logic [1:0] RECOVER_LOAD = 2'(PULLUP_CYCLES);

    // recovery window blocks a pull right after release
    wire recovering = (recover != 2'h0);

    always_comb begin
        next_ready_active = ready_active;
        if (reset_seen) begin
            next_ready_active = 1'b1;
        end else if (status_active) begin
            next_ready_active = 1'b0;
        end else if (ready_active && source_drop) begin
            next_ready_active = 1'b0;
        end else if (!ready_active && !recovering && source_take) begin
            next_ready_active = 1'b1;
        end else if (!ready_active) begin
            next_ready_active = 1'b0;
        end
    end

    // reset_seen lags the synced reset one clock before forcing ready
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ready_active <= 1'b0;
            recover <= 2'h0;
            reset_seen <= 1'b0;
        end else begin
            reset_seen <= rst_sync;
            ready_active <= next_ready_active;
            if (status_active && !reset_seen) begin
                recover <= RECOVER_LOAD;
            end else if (recovering) begin
                recover <= recover - 2'h1;
            end
        end
    end

    // open collector: data always low, enable pulls
    assign ready_pin.ready_out = 1'b0;
    assign ready_pin.ready_oe = ready_active;

    // =========================================================
    // assertions
    // =========================================================
    // a cycle start seen while no system reset forces the line
    sequence s_release;
        status_active && !reset_seen;
    endsequence
    // status idle again, with no reset forcing the line
    sequence s_idle_pair;
        (!status_active && !reset_seen)[*2];
    endsequence
    property p_status_release;
        @(posedge mclk) disable iff (!rstn)
        s_release |=> !ready_pin.ready_oe;
    endproperty
    a_status_release: assert property (p_status_release)
        else $error("ready not released on cycle start");

    // checks only the first cycle of the window, which any legal count covers
    property p_recovery;
        @(posedge mclk) disable iff (!rstn)
        s_release ##1 s_idle_pair |-> !ready_pin.ready_oe;
    endproperty
    a_recovery: assert property (p_recovery)
        else $error("ready pulled inside recovery window");

    property p_reset_ready;
        @(posedge mclk) disable iff (!rstn)
        $rose(rst_sync) |=> reset_seen ##1 ready_pin.ready_oe;
    endproperty
    a_reset_ready: assert property (p_reset_ready)
        else $error("ready not forced during reset");

    property p_sync_pull;
        @(posedge mclk) disable iff (!rstn)
        (!reset_seen && !ready_active && !recovering && sync_take)
        |=> ready_pin.ready_oe;
    endproperty
    a_sync_pull: assert property (p_sync_pull)
        else $error("sync ready did not pull");

    property p_async_pull;
        @(posedge mclk) disable iff (!rstn)
        (!reset_seen && !status_active && !ready_active && !recovering
         && async_take) |=> ready_pin.ready_oe;
    endproperty
    a_async_pull: assert property (p_async_pull)
        else $error("async ready did not pull");

    property p_pclk_half;
        @(posedge mclk) disable iff (!rstn)
        pclk |=> !pclk ##1 pclk;
    endproperty
    a_pclk_half: assert property (p_pclk_half)
        else $error("pclk not half rate");

    property p_open_collector;
        @(posedge mclk) disable iff (!rstn)
        ready_pin.ready_oe |-> !ready_pin.ready_out;
    endproperty
    a_open_collector: assert property (p_open_collector)
        else $error("ready driven high");

    property p_wait_state;
        @(posedge mclk) disable iff (!rstn)
        (!reset_seen && !ready_active && !source_take) |=>
        !ready_pin.ready_oe;
    endproperty
    a_wait_state: assert property (p_wait_state)
        else $error("ready pulled with no source");

    property p_hold_drop;
        @(posedge mclk) disable iff (!rstn)
        (!reset_seen && ready_active && source_drop) |=>
        !ready_pin.ready_oe;
    endproperty
    a_hold_drop: assert property (p_hold_drop)
        else $error("ready held after inputs inactive");

endmodule

// [verif/brg_bus_partner.sv]
`timescale 1ns/1ps
// =========================================================
// processor status and address decoder stand-in
// =========================================================
module brg_bus_partner (
    // clock
    input wire logic mclk,
    // requests from the bench: kind bit 0 sync, bit 1 async
    input wire logic [1:0] ready_kind,
    input wire logic wrong_pair,
    // cycle start on the low or on the high status bit
    input wire logic cycle_start,
    input wire logic cycle_high,
    // pins towards the ready generator
    output brg_pkg::brg_ready_src_s ready_src,
    output brg_pkg::brg_status_s status
);
    // wrong_pair selects a source whose device is not ready yet
    wire logic sync_ok = (ready_kind == 2'h1) && !wrong_pair;
    wire logic async_ok = ready_kind[1] && !wrong_pair;

    // one process owns the pins: idle inactive high, as the pull-ups
    // leave them, then moved on each falling edge, clear of sampling
    initial begin
        ready_src = 4'hf;
        status = 2'h3;
        forever begin
            @(negedge mclk);
            ready_src.sync_ready_enable_n <= ~ready_kind[0];
            ready_src.sync_ready_in_n <= ~sync_ok;
            ready_src.async_ready_enable_n <= ~ready_kind[1];
            ready_src.async_ready_in_n <= ~async_ok;
            status.cycle_status_low_n <= ~cycle_start;
            status.cycle_status_high_n <= ~cycle_high;
        end
    end
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    // =========================================================
    // clock, reset and pins
    // =========================================================
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic sys_reset = 1'b0;
    logic [1:0] ready_kind = 2'h0;
    logic wrong_pair = 1'b0;
    logic cycle_start = 1'b0;
    logic cycle_high = 1'b0;
    logic pclk;
    logic p;
    logic hit;
    brg_pkg::brg_ready_src_s ready_src;
    brg_pkg::brg_status_s status;
    brg_pkg::brg_ready_pin_s ready_pin;
    int miscompares = 0;
    int num_checks = 0;
    // the line as the pull-up and the open-collector pin leave it
    wire logic ready_line = ready_pin.ready_oe ? ready_pin.ready_out : 1'b1;

    // 125 MHz
    always #4 mclk = ~mclk;

    brg_ready_gen u_brg_ready_gen (.mclk(mclk), .rstn(rstn),
        .sys_reset(sys_reset), .ready_src(ready_src), .status(status),
        .pclk(pclk), .ready_pin(ready_pin));
    brg_bus_partner u_brg_bus_partner (.mclk(mclk), .ready_kind(ready_kind),
        .wrong_pair(wrong_pair), .cycle_start(cycle_start),
        .cycle_high(cycle_high),
        .ready_src(ready_src), .status(status));

    // =========================================================
    // shared tasks
    // =========================================================
    task automatic check(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    // bounded wait for the pull to reach a level, seen at falling edges
    task automatic wait_oe(input logic lvl, input int lim, output logic ok);
        ok = 1'b0;
        while (lim > 0 && !ok) begin
            @(negedge mclk);
            ok = (ready_pin.ready_oe === lvl);
            lim--;
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // =========================================================
    // scenarios
    // =========================================================
    task automatic t_idle;
        @(negedge mclk);
        check("oe idle", 1'b0, ready_pin.ready_oe);
        p = pclk;
        @(negedge mclk);
        check("pclk", ~p, pclk);
        @(negedge mclk);
        check("pclk", p, pclk);
    endtask

    // kind 3 keeps the sync pair half-selected: async must still win
    // controls change by non-blocking assignment at the falling edge,
    // so the partner sees them one falling edge later, never racing
    task automatic t_source(input logic [1:0] kind);
        ready_kind <= kind;
        wait_oe(1'b1, 8, hit);
        check("pull", 1'b1, hit);
        check("line low", 1'b0, ready_line);
        check("pin data", 1'b0, ready_pin.ready_out);
        ready_kind <= 2'h0;
        wait_oe(1'b0, 8, hit);
        check("let go", 1'b1, hit);
    endtask

    // enable without ready must leave wait states running
    task automatic t_wait_state(input logic [1:0] kind);
        ready_kind <= kind;
        wrong_pair <= 1'b1;
        wait_oe(1'b1, 10, hit);
        check("no pull", 1'b0, hit);
        ready_kind <= 2'h0;
        wrong_pair <= 1'b0;
        // one edge between this clear and the next request
        @(negedge mclk);
    endtask

    // cycle start on either status bit, then the recovery window
    task automatic t_cycle_start(input logic hi);
        ready_kind <= 2'h2;
        wait_oe(1'b1, 8, hit);
        check("async pull", 1'b1, hit);
        if (hi) begin
            cycle_high <= 1'b1;
        end else begin
            cycle_start <= 1'b1;
        end
        wait_oe(1'b0, 8, hit);
        check("start release", 1'b1, hit);
        @(negedge mclk);
        check("recovery", 1'b0, ready_pin.ready_oe);
        cycle_start <= 1'b0;
        cycle_high <= 1'b0;
        // status is seen idle three edges on; the pull must wait two more
        repeat (5) begin
            @(negedge mclk);
            check("recovery", 1'b0, ready_pin.ready_oe);
        end
        wait_oe(1'b1, 10, hit);
        check("pull again", 1'b1, hit);
        ready_kind <= 2'h0;
        wait_oe(1'b0, 8, hit);
        check("idle again", 1'b1, hit);
    endtask

    task automatic t_sys_reset;
        cycle_start <= 1'b1;
        sys_reset <= 1'b1;
        wait_oe(1'b1, 8, hit);
        check("reset pull", 1'b1, hit);
        sys_reset <= 1'b0;
        cycle_start <= 1'b0;
        wait_oe(1'b0, 8, hit);
        check("reset let go", 1'b1, hit);
    endtask

    // =========================================================
    // main sequence and watchdog
    // =========================================================
    initial begin
        repeat (16) @(negedge mclk);
        rstn = 1'b1;
        t_idle;
        t_source(2'h1);
        t_source(2'h2);
        t_source(2'h3);
        t_wait_state(2'h1);
        t_wait_state(2'h2);
        t_cycle_start(1'b0);
        t_cycle_start(1'b1);
        t_sys_reset;
        close_out;
    end

    // whole run needs about 115 cycles; 2500 is ample margin
    initial begin
        #20000;
        miscompares++;
        close_out;
    end
endmodule
